// ---- io_exp_pkg.sv ----
// Purpose: shared constants for the expander access register block
// Assumes: 32-bit AXI4-Lite data, one word per register
// Notes:   offsets are byte addresses
package io_exp_pkg;
   localparam logic [11:0] ACCESS_OFS    = 12'h430;
   localparam logic [11:0] ADDR0_OFS     = 12'h434;
   localparam logic [11:0] ADDR1_OFS     = 12'h438;
   localparam logic [11:0] SELECT_OFS    = 12'h43C;
   localparam logic [11:0] STATUS_OFS    = 12'h440;
   localparam logic [11:0] MASK_OFS      = 12'h444;
   localparam logic [31:0] ACCESS_RESET  = 32'h0000_0000;
   localparam int          DATA_LSB      = 0;
   localparam int          REFRESH_BIT   = 24;
   localparam int          TEST_BIT      = 25;
   localparam int          SEL_LSB       = 26;
   localparam int          DONE_BIT      = 31;
   localparam int          NUM_EXP       = 5;
   localparam logic [2:0]  SEL_MAX       = 3'h4;
   localparam int          ADDR_STRIDE   = 8;
   localparam int          ADDR_LSB      = 1;
   localparam int          SEND_BITS     = 24;
   localparam int          RECV_BITS     = 16;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : io_exp_pkg

// ---- exp_txn_if.sv ----
// Purpose: request and answer path to the serial transaction engine
// Assumes: both ends on aclk
// Notes:   start is a one-cycle pulse taken only while busy is low
`timescale 1ns/1ps
interface exp_txn_if;
   logic        start;
   logic [2:0]  idx;
   logic [6:0]  addr;
   logic [15:0] out_data;
   logic        busy;
   logic        done;
   logic [2:0]  done_idx;
   logic [15:0] in_data;
   modport master (output start, idx, addr, out_data,
                   input busy, done, done_idx, in_data);
   modport engine (input start, idx, addr, out_data,
                   output busy, done, done_idx, in_data);
endinterface : exp_txn_if

// ---- exp_txn_engine.sv ----
// Purpose: serial frame to one expander: address and outputs, then inputs
// Assumes: link clock driven by the far side, sampled on aclk
// Notes:   drives on link clock falls, samples on link clock rises
`timescale 1ns/1ps
module exp_txn_engine
   import io_exp_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic link_clk,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_n,
   exp_txn_if.engine txn
);
   import io_exp_pkg::*;

   typedef enum logic [1:0] {
      IDLE = 2'h0, SEND = 2'h1, RECV = 2'h3, FIN = 2'h2
   } eng_state_t;

   typedef struct packed {
      logic        lk1, lk2, lk3;
      logic        sd1, sd2;
      eng_state_t  fsm;
      logic [4:0]  cnt;
      logic [23:0] shout;
      logic [15:0] shin;
      logic [2:0]  idx;
      logic        sda_o, sda_oe_n, done;
   } eng_t;

   eng_t st, next_st;
   logic rise, fall;

   ////////////////////////////////////////////////////////////////////
   // edge detect reads only the second and third stages
   assign rise = st.lk2 & ~st.lk3;
   assign fall = ~st.lk2 & st.lk3;

   always_comb begin
      next_st      = st;
      next_st.lk1  = link_clk;
      next_st.lk2  = st.lk1;
      next_st.lk3  = st.lk2;
      next_st.sd1  = sda_i;
      next_st.sd2  = st.sd1;
      next_st.done = 1'b0;
      case (st.fsm)
         IDLE: begin
            if (txn.start) begin
               next_st.fsm   = SEND;
               next_st.cnt   = 5'h00;
               next_st.idx   = txn.idx;
               next_st.shout = {txn.addr, 1'b0, txn.out_data};
            end
         end
         SEND: begin
            if (fall) begin
               if (st.cnt == 5'(SEND_BITS)) begin
                  next_st.fsm      = RECV;  // release line for inputs
                  next_st.cnt      = 5'h00;
                  next_st.sda_oe_n = 1'b1;
               end else begin
                  next_st.sda_o    = st.shout[23];
                  next_st.sda_oe_n = 1'b0;
                  next_st.shout    = {st.shout[22:0], 1'b0};
                  next_st.cnt      = st.cnt + 5'h01;
               end
            end
         end
         RECV: begin
            if (rise) begin
               next_st.shin = {st.shin[14:0], st.sd2};
               next_st.cnt  = st.cnt + 5'h01;
               if (st.cnt == 5'(RECV_BITS - 1)) next_st.fsm = FIN;
            end
         end
         FIN: begin
            next_st.done = 1'b1;
            next_st.fsm  = IDLE;
         end
         default: next_st.fsm = IDLE;
      endcase
   end

   // whole state in one register, frozen while ce is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st          <= '0;
         st.sda_oe_n <= 1'b1;
         st.sda_o    <= 1'b1;
         // link idles high: start there, so no false edge after reset
         st.lk1      <= 1'b1;
         st.lk2      <= 1'b1;
         st.lk3      <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign sda_o        = st.sda_o;
   assign sda_oe_n     = st.sda_oe_n;
   assign txn.busy     = (st.fsm != IDLE);
   assign txn.done     = st.done;
   assign txn.done_idx = st.idx;
   assign txn.in_data  = st.shin;
endmodule : exp_txn_engine

// ---- io_expander_access_register.sv ----
// Purpose: software access register for the serial I/O expanders
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   one queued refresh per expander; repeats merge
`timescale 1ns/1ps

// Notes on behaviour
// - read returns selected expander pin values
// - pin writes dropped unless override test set
// - override plus refresh sends software outputs
// - input pin bits never writable
// - refresh write launches an expander transaction
// - refresh bit always reads zero
// - override mode ignores core output values
// - selector picks expander, codes above four reserved
// - done flag sticky, cleared by writing one
// - done after refresh of selected expander
// - done after override write transaction finishes
// - done after selected expander initialization finishes
// - each expander has own seven-bit bus address
module io_expander_access_register
   import io_exp_pkg::*;
#(
   parameter int          ADDR_W     = 12,
   parameter logic [15:0] INPUT_MASK = 16'h00FF
)(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   input  wire logic [ADDR_W-1:0]    awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire logic [ADDR_W-1:0]    araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   input  wire logic [4:0][15:0]     core_out_values,
   input  wire logic                 link_clk,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe_n,
   output logic                      irq
);
   import io_exp_pkg::*;

   typedef struct packed {
      logic            awready, wready, bvalid;
      logic [1:0]      bresp;
      logic            arready, rvalid;
      logic [1:0]      rresp;
      logic [31:0]     rdata;
      logic [4:0][15:0] pins;
      logic [4:0][15:0] ovr;
      logic [4:0][6:0] eaddr;
      logic [2:0]      sel;
      logic            test, done, mask, irq;
      logic [4:0]      pend;
      logic            start;
      logic [2:0]      tidx;
      logic [6:0]      taddr;
      logic [15:0]     tout;
   } regs_t;

   regs_t st, next_st;
   exp_txn_if txn ();

   ////////////////////////////////////////////////////////////////////
   // byte lanes to bit mask, used for the access and status registers
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      for (int b = 0; b < 4; b++) lane_mask[b*8 +: 8] = {8{s[b]}};
   endfunction : lane_mask

   // lowest pending expander, served first
   function automatic logic [2:0] first_pend(input logic [4:0] p);
      first_pend = 3'h0;
      for (int i = NUM_EXP - 1; i >= 0; i--) begin
         if (p[i]) first_pend = 3'(i);
      end
   endfunction : first_pend

   logic [11:0] wofs, rofs;
   logic [31:0] wm, wv;
   logic        wr_go, rd_go, clr_done, set_done;
   assign wofs = 12'(awaddr);
   assign rofs = 12'(araddr);
   assign wm   = lane_mask(wstrb);
   assign wr_go = awvalid & wvalid & ~st.bvalid & ~st.awready;
   assign rd_go = arvalid & ~st.rvalid & ~st.arready;
   assign wv   = wdata & wm;

   ////////////////////////////////////////////////////////////////////
   // register file, launch queue and completion bookkeeping
   always_comb begin
      logic [2:0] k;
      k         = 3'h0;
      clr_done  = 1'b0;
      set_done  = 1'b0;
      next_st   = st;
      next_st.awready = 1'b0;
      next_st.wready  = 1'b0;
      next_st.arready = 1'b0;
      next_st.start   = 1'b0;
      if (st.bvalid && bready) next_st.bvalid = 1'b0;
      if (st.rvalid && rready) next_st.rvalid = 1'b0;

      // write channel: take address and data together
      if (wr_go) begin
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         case (wofs)
            ACCESS_OFS: begin
               if (wm[DATA_LSB] && wm[DATA_LSB+8] && st.test) begin
                  // inputs masked off, test gate on the write
                  next_st.ovr[st.sel] = wdata[15:0] & ~INPUT_MASK;
                  next_st.pend[st.sel] = 1'b1;
               end
               if (wm[REFRESH_BIT] && wdata[REFRESH_BIT])
                  next_st.pend[st.sel] = 1'b1;
               if (wm[TEST_BIT]) next_st.test = wdata[TEST_BIT];
               if (wm[DONE_BIT] && wdata[DONE_BIT]) clr_done = 1'b1;
            end
            ADDR0_OFS, ADDR1_OFS: begin
               for (int i = 0; i < NUM_EXP; i++) begin
                  if ((wofs == ADDR0_OFS) == (i < 4)
                      && wstrb[i % 4]) begin
                     next_st.eaddr[i] =
                        wdata[(i % 4)*ADDR_STRIDE + ADDR_LSB +: 7];
                     next_st.pend[i] = 1'b1;
                  end
               end
            end
            SELECT_OFS: begin
               // reserved codes refused, selection stays valid
               if (wstrb[0] && wdata[7:0] <= 8'(SEL_MAX))
                  next_st.sel = wdata[2:0];
            end
            STATUS_OFS: if (wv[0]) clr_done = 1'b1;
            MASK_OFS:   if (wstrb[0]) next_st.mask = wdata[0];
            default:    next_st.bresp = RESP_SLVERR;
         endcase
      end

      // read channel: data registered with the address handshake
      if (rd_go) begin
         next_st.arready = 1'b1;
         next_st.rvalid  = 1'b1;
         next_st.rresp   = RESP_OKAY;
         next_st.rdata   = 32'h0000_0000;
         case (rofs)
            ACCESS_OFS: begin
               next_st.rdata[15:0] = st.pins[st.sel];
               next_st.rdata[REFRESH_BIT] = 1'b0;
               next_st.rdata[TEST_BIT] = st.test;
               next_st.rdata[SEL_LSB +: 4] = {1'b0, st.sel};
               next_st.rdata[DONE_BIT] = st.done;
            end
            ADDR0_OFS: begin
               for (int i = 0; i < 4; i++)
                  next_st.rdata[i*ADDR_STRIDE + ADDR_LSB +: 7] =
                     st.eaddr[i];
            end
            ADDR1_OFS:  next_st.rdata[ADDR_LSB +: 7] = st.eaddr[4];
            SELECT_OFS: next_st.rdata[2:0] = st.sel;
            STATUS_OFS: next_st.rdata[0] = st.done;
            MASK_OFS:   next_st.rdata[0] = st.mask;
            default:    next_st.rresp = RESP_SLVERR;
         endcase
      end

      // launch the next queued expander once the engine is idle
      if (!txn.busy && !st.start && st.pend != 5'h00) begin
         k = first_pend(st.pend);
         next_st.start   = 1'b1;
         next_st.tidx    = k;
         next_st.taddr   = next_st.eaddr[k];
         next_st.pend[k] = 1'b0;
         // core outputs ignored while override test is on; same-cycle
         // writes included, so a merged request never sends stale data
         next_st.tout = (st.test ? next_st.ovr[k] : core_out_values[k])
                        & ~INPUT_MASK;
         next_st.pins[k] = (st.pins[k] & INPUT_MASK) | next_st.tout;
      end

      // inputs land on completion; flag only for selected expander
      if (txn.done) begin
         next_st.pins[txn.done_idx] = (txn.in_data & INPUT_MASK)
            | (next_st.pins[txn.done_idx] & ~INPUT_MASK); // keeps launch
         if (txn.done_idx == st.sel) set_done = 1'b1;
      end
      // set wins over a clear in the same cycle
      if (clr_done) next_st.done = 1'b0;
      if (set_done) next_st.done = 1'b1;
      next_st.irq = next_st.done & next_st.mask;
   end

   // all state held in one register, frozen while ce is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // serial engine and output wiring
   assign txn.start    = st.start;
   assign txn.idx      = st.tidx;
   assign txn.addr     = st.taddr;
   assign txn.out_data = st.tout;

   exp_txn_engine u_engine (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .link_clk (link_clk),
      .sda_i    (sda_i),
      .sda_o    (sda_o),
      .sda_oe_n (sda_oe_n),
      .txn      (txn.engine)
   );

   assign awready = st.awready;
   assign wready  = st.wready;
   assign bvalid  = st.bvalid;
   assign bresp   = st.bresp;
   assign arready = st.arready;
   assign rvalid  = st.rvalid;
   assign rresp   = st.rresp;
   assign rdata   = st.rdata;
   assign irq     = st.irq;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   logic rd_acc, wr_acc;
   assign rd_acc = rd_go && rofs == ACCESS_OFS;
   assign wr_acc = wr_go && wofs == ACCESS_OFS;

   refresh_reads_zero_a: assert property (
      rd_acc |=> rvalid && !rdata[REFRESH_BIT])
      else $error("refresh bit read as one");
   reserved_read_zero_a: assert property (
      rd_acc |=> rdata[23:16] == 8'h00 && !rdata[30])
      else $error("reserved bits not zero");
   pin_write_drop_a: assert property (
      wr_acc && !st.test |=> $stable(st.ovr))
      else $error("pin write taken outside test mode");
   input_bits_ro_a: assert property (
      (st.ovr[st.sel] & INPUT_MASK) == 16'h0000)
      else $error("input bit written");
   done_sticky_a: assert property (
      st.done && !(wr_go && (wofs == ACCESS_OFS || wofs == STATUS_OFS))
      |=> st.done)
      else $error("done flag lost");
   done_on_finish_a: assert property (
      txn.done && txn.done_idx == st.sel |=> st.done)
      else $error("done not set on completion");
   refresh_launch_a: assert property (
      wr_acc && wm[REFRESH_BIT] && wdata[REFRESH_BIT] && !st.start
      |=> st.pend != 5'h00 || st.start)
      else $error("refresh not queued");
   override_source_a: assert property (
      st.start |-> st.tout == (($past(st.test) ? st.ovr[st.tidx]
         : $past(core_out_values[next_st.tidx])) & ~INPUT_MASK))
      else $error("wrong output source");
   select_range_a: assert property (
      st.sel <= SEL_MAX)
      else $error("reserved select code");
   address_used_a: assert property (
      st.start |-> st.taddr == st.eaddr[st.tidx])
      else $error("wrong expander address");
   irq_level_a: assert property (
      irq == (st.done && st.mask))
      else $error("irq does not follow flag and mask");

   // write address and data are always taken together
   write_pair_a: assert property (
      awready == wready && (!awready || bvalid))
      else $error("write channels split");

   read_answer_a: assert property (
      rd_go |=> arready && rvalid)
      else $error("read not answered");

   test_bit_store_a: assert property (
      wr_acc && wm[TEST_BIT] |=> st.test == $past(wdata[TEST_BIT]))
      else $error("test bit not stored");

   // completion of another expander must leave the flag alone
   done_other_exp_a: assert property (
      txn.done && txn.done_idx != st.sel && !st.done |=> !st.done)
      else $error("done set for unselected expander");

   // one frame at a time: a launch only meets an idle engine
   launch_idle_a: assert property (
      st.start |-> !txn.busy ##1 !st.start && txn.busy)
      else $error("launch while engine busy");

   pins_input_a: assert property (
      txn.done |=> ((st.pins[$past(txn.done_idx)] ^ $past(txn.in_data))
                    & INPUT_MASK) == 16'h0000)
      else $error("inputs not stored");

   override_queue_a: assert property (
      wr_acc && st.test && wm[DATA_LSB] && wm[DATA_LSB+8]
      |=> st.pend[st.sel] || (st.start && st.tidx == st.sel))
      else $error("override write not queued");

   init_queue_a: assert property (
      wr_go && wofs == ADDR0_OFS && wstrb[0]
      |=> st.pend[0] || (st.start && st.tidx == 3'h0))
      else $error("address write not queued");

   refresh_done_c: cover property (
      wr_acc && wdata[REFRESH_BIT] ##[1:1000] st.done);
   override_done_c: cover property (
      st.test && st.start ##[1:1000] txn.done);
   set_clear_c: cover property (set_done && clr_done);
   init_done_c: cover property (
      wr_go && wofs == ADDR0_OFS ##[1:1000] st.done);
endmodule : io_expander_access_register

// ---- exp_partner.sv ----
// Purpose: behavioural expander on the serial link
// Assumes: line pulled up while nobody drives it
// Notes:   link clock runs only inside a frame started by go
`timescale 1ns/1ps
module exp_partner (
   input  wire logic        go,
   input  wire logic [15:0] in_bits,
   input  wire logic        sda_o,
   input  wire logic        sda_oe_n,
   output logic             link_clk,
   output logic             sda_i,
   output logic             busy,
   output logic [23:0]      got
);
   logic drv_en;
   logic drv_bit;
   ////////////////////////////////////////////////////////////
   // wired line: device, then this model, else the pull-up
   assign sda_i = !sda_oe_n ? sda_o : (drv_en ? drv_bit : 1'b1);
   initial begin
      link_clk = 1'b1;
      busy     = 1'b0;
      drv_en   = 1'b0;
      drv_bit  = 1'b1;
      got      = '0;
   end
   // 40 periods: 24 bits taken in, then 16 inputs sent MSB first
   always @(posedge go) begin
      busy = 1'b1;
      got  = '0;
      #80;
      for (int k = 1; k <= 40; k++) begin
         link_clk = 1'b0;
         if (k >= 25) begin
            drv_en  = 1'b1;
            drv_bit = in_bits[40-k];
         end
         #80;
         link_clk = 1'b1;
         if (k <= 24) got = {got[22:0], sda_i};
         #80;
      end
      drv_en = 1'b0; // released: pull-up takes over
      busy   = 1'b0;
   end
endmodule : exp_partner

// ---- tb_top.sv ----
// Purpose: self-checking bench for the expander access register
// Assumes: one expander model on the link, ce held high
// Notes:   expander 0 is at bus address 0x5A
`timescale 1ns/1ps
module tb_top;
   import io_exp_pkg::*;
   logic             aclk, aresetn, awvalid, awready, wvalid, wready;
   logic             bvalid, bready, arvalid, arready, rvalid, rready;
   logic [11:0]      awaddr, araddr;
   logic [31:0]      wdata, rdata, rv;
   logic [3:0]       wstrb;
   logic [1:0]       bresp, rresp;
   logic [4:0][15:0] core;
   logic             link_clk, sda_i, sda_o, sda_oe_n, irq, go, busy;
   logic [15:0]      in_bits;
   logic [23:0]      got;
   int               n_fail;
   int               checks;

   io_expander_access_register u_dut (.aclk, .aresetn, .ce(1'b1),
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .core_out_values(core), .link_clk,
      .sda_i, .sda_o, .sda_oe_n, .irq);
   exp_partner u_exp (.go, .in_bits, .sda_o, .sda_oe_n, .link_clk,
      .sda_i, .busy, .got);

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////
   task check(input string nm, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // write: aw and w offered together, bready held until bvalid
   task wr(input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin @(posedge aclk); n++; end
      while (awready !== 1'b1 && n < 100);
      awvalid <= 1'b0; wvalid <= 1'b0;
      while (bvalid !== 1'b1 && n < 100) begin @(posedge aclk); n++; end
      bready <= 1'b0;
      if (bvalid !== 1'b1) n_fail++; // wait limit ran out
      check("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr
   task rd(input logic [11:0] a, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin @(posedge aclk); n++; end
      while (arready !== 1'b1 && n < 100);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 100) begin @(posedge aclk); n++; end
      rready <= 1'b0;
      if (rvalid !== 1'b1) n_fail++; // wait limit ran out
      rv = rdata;
      check("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rd
   // one frame from the expander model, then let the flags settle
   task frame(input logic [15:0] ib);
      int n;
      n = 0;
      in_bits <= ib;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do begin @(posedge aclk); n++; end
      while (busy === 1'b1 && n < 2000);
      if (busy === 1'b1) n_fail++; // frame never ended
      repeat (10) @(posedge aclk);
   endtask : frame
   task give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////
   // watchdog: the whole run needs well under 10k cycles
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
   initial begin
      n_fail = 0; checks = 0; aresetn = 1'b0; go = 1'b0;
      awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0;
      wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
      rready = 1'b0; in_bits = '0; core = {5{16'hA55A}};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ACCESS_OFS, RESP_OKAY);
      check("reset", rv, ACCESS_RESET);
      // address of expander 0 only: one init frame
      wr(ADDR0_OFS, 32'h0000_00B4, 4'b0001, RESP_OKAY);
      frame(16'h0000);
      check("init frame", {8'h0, got}, 32'h00B4_A500);
      rd(STATUS_OFS, RESP_OKAY);
      check("init done", rv, 32'h1);
      rd(ADDR0_OFS, RESP_OKAY);
      check("addr0", rv, 32'h0000_00B4);
      wr(ACCESS_OFS, 32'h8000_0000, 4'b1111, RESP_OKAY);
      rd(STATUS_OFS, RESP_OKAY);
      check("done clr", rv, 32'h0);
      // refresh with interrupt unmasked
      wr(MASK_OFS, 32'h1, 4'b1111, RESP_OKAY);
      wr(ACCESS_OFS, 32'h0100_0000, 4'b1111, RESP_OKAY);
      frame(16'h123C);
      check("refresh frame", {8'h0, got}, 32'h00B4_A500);
      check("irq set", {31'h0, irq}, 32'h1);
      rd(ACCESS_OFS, RESP_OKAY);
      check("pins", rv, 32'h8000_A53C);
      check("refresh rd", {31'h0, rv[REFRESH_BIT]}, 32'h0);
      // pins and reserved bits written with override off
      wr(ACCESS_OFS, 32'h40FF_0000, 4'b1111, RESP_OKAY);
      rd(ACCESS_OFS, RESP_OKAY);
      check("no override", rv, 32'h8000_A53C);
      check("reserved", rv & 32'h40FF_0000, 32'h0);
      wr(STATUS_OFS, 32'h1, 4'b1111, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check("irq clr", {31'h0, irq}, 32'h0);
      // override plus refresh: software outputs go out; test mode is
      // set first, a pin write counts only once it is already on
      wr(ACCESS_OFS, 32'h0200_0000, 4'b1111, RESP_OKAY);
      wr(ACCESS_OFS, 32'h0300_C3C3, 4'b1111, RESP_OKAY);
      frame(16'h0011);
      check("override frame", {8'h0, got}, 32'h00B4_C300);
      check("core ignored", {8'h0, got}, 32'h00B4_C300);
      rd(ACCESS_OFS, RESP_OKAY);
      check("override pins", rv, 32'h8200_C311);
      check("inputs ro", {24'h0, rv[7:0]}, 32'h11);
      // init of unselected expander 4: frame goes out, no done flag
      wr(STATUS_OFS, 32'h1, 4'b1111, RESP_OKAY);
      wr(ADDR1_OFS, 32'h0000_0042, 4'b0001, RESP_OKAY);
      frame(16'h0000);
      check("exp4 frame", {8'h0, got}, 32'h0042_0000);
      rd(STATUS_OFS, RESP_OKAY);
      check("other done", rv, 32'h0);
      // selector: reserved code dropped, top code taken
      wr(SELECT_OFS, 32'h7, 4'b1111, RESP_OKAY);
      rd(SELECT_OFS, RESP_OKAY);
      check("sel rsvd", rv, 32'h0);
      wr(SELECT_OFS, {29'h0, SEL_MAX}, 4'b1111, RESP_OKAY);
      rd(ACCESS_OFS, RESP_OKAY);
      check("sel field", rv & 32'h3C00_0000, 32'h1000_0000);
      // unmapped offset
      wr(12'h448, 32'hFFFF_FFFF, 4'b1111, RESP_SLVERR);
      rd(12'h448, RESP_SLVERR);
      check("unmapped", rv, 32'h0);
      give_verdict();
   end
endmodule : tb_top
